// [rtl/cei_params.svh]
// Purpose: constants of the compute engine interface
// Assumes: 50 MHz ref_clk, 32768 Hz time base made by division
// Notes: definitions only
`ifndef CEI_PARAMS_SVH
`define CEI_PARAMS_SVH
`define CLK_HZ 50000000
`define TB_HZ 32768
// time-base period rounds down: 1525 clocks, slightly fast
`define TICK_DIV (`CLK_HZ / `TB_HZ)
`define TICK_W 11
`define FRAME_LAST 4'hC
`define SETTLE_CYC 4'h0
`define ALT_EVERY 4'hF
`define PRESAMP_0 7'h2A
`define PRESAMP_1 7'h32
`define PRESAMP_2 7'h54
`define PRESAMP_3 7'h64
`define SHUNT_SHIFT 3
`define WORD_SUM0 3'h0
`define WORD_SUM1 3'h1
`define WORD_SQ0 3'h2
`define WORD_SQ1 3'h3
`define WORD_STAT 3'h4
`define WORD_HOST0 3'h5
`define WORD_RESET 32'h0000_0000
`define MINUS_ONE 32'hFFFF_FFFF
`endif

// [rtl/cei_pkg.sv]
// Purpose: types of the compute engine interface
// Assumes: constants come from cei_params.svh
// Notes: state record is registered as one unit
package cei_pkg;
   typedef enum logic [2:0] {
      EQ_TAMPER = 3'b000,
      EQ_THREEWIRE = 3'b001,
      EQ_TWOELEM = 3'b010
   } equ_t;

   typedef struct packed {
      logic [10:0] tickCnt;
      logic [3:0] frameCyc;
      logic [3:0] frameCnt;
      logic [12:0] sampCnt;
      logic [31:0] sum0;
      logic [31:0] sum1;
      logic [31:0] sq0;
      logic [31:0] sq1;
      logic [7:0][31:0] mem;
      logic [7:0] rdData;
      logic sampleStrobe;
      logic accumDone;
      logic altFrame;
      logic chopPol;
      logic sagA;
      logic sagB;
   } cei_state_t;
endpackage

// [rtl/compute_engine_interface.sv]
// Purpose: engine word store, frame timing and meter-equation sums
// Assumes: all inputs synchronous to ref_clk; samples valid at frame end
// Notes: host side reads bytes big-endian; outputs from flip-flops except programVariant, decoded from meter_equation_select
// Behaviour
// - engine words are 32-bit two's complement
// - most significant byte at lowest byte address
// - chop code 00 chops and inserts alternate frames
// - frame is thirteen ticks, one settling
// - interval holds multiplier times count samples, one sample when count is zero
// - equation 0: VA*IA, VA*IB, IA, IB
// - equation 1: halved VA*(IA-IB), halved VA*IB
// - equation 2: VA*IA, VB*IB, IA, IB
// - variant for 0 differs from 1 and 2
// - sag threshold LSB is full-scale times 7.8798e-6
`timescale 1ns/1ps
`default_nettype none
`include "cei_params.svh"
module compute_engine_interface
   import cei_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic engineEnable,
   input wire logic [2:0] meter_equation_select,
   input wire logic [1:0] presample_multiplier,
   input wire logic [5:0] accumulation_cycle_count,
   input wire logic [1:0] chop_control,
   input wire logic iaShunt,
   input wire logic ibShunt,
   input wire logic signed [11:0] va,
   input wire logic signed [11:0] vb,
   input wire logic signed [11:0] ia,
   input wire logic signed [11:0] ib,
   input wire logic [11:0] sag_threshold,
   input wire logic [4:0] hostAddr,
   input wire logic hostRd,
   input wire logic hostWr,
   input wire logic [7:0] hostWrData,
   output logic [7:0] hostRdData,
   output logic programVariant,
   output logic sampleStrobe,
   output logic accumDone,
   output logic altFrame,
   output logic chopPolarity,
   output logic sagA,
   output logic sagB
);
   cei_state_t q;
   cei_state_t d;
   logic tick;
   logic frameEnd;
   logic signed [14:0] iaG;
   logic signed [14:0] ibG;
   logic signed [31:0] p0;
   logic signed [31:0] p1;
   logic signed [31:0] s0;
   logic signed [31:0] s1;
   logic signed [15:0] iDiff;
   logic [12:0] target;

   // multiplier code to sample multiplier
   function automatic logic [6:0] presampMul(input logic [1:0] code);
      logic [6:0] m;
      m = `PRESAMP_0;
      if (code == 2'h1) begin
         m = `PRESAMP_1;
      end else if (code == 2'h2) begin
         m = `PRESAMP_2;
      end else if (code == 2'h3) begin
         m = `PRESAMP_3;
      end
      return m;
   endfunction

   // byte lane of a word; lane 0 is the most significant byte
   function automatic logic [4:0] laneBase(input logic [1:0] lane);
      return 5'(8 * (3 - int'(lane)));
   endfunction

   // magnitude of a sample, for sag compare
   function automatic logic [11:0] mag(input logic signed [11:0] x);
      return x[11] ? 12'(-x) : 12'(x);
   endfunction

   // current gain: shunt inputs get eight times
   assign iaG = iaShunt ? 15'(ia) <<< `SHUNT_SHIFT : 15'(ia);
   assign ibG = ibShunt ? 15'(ib) <<< `SHUNT_SHIFT : 15'(ib);
   assign iDiff = 16'(iaG) - 16'(ibG);
   // interval length is multiplier times count; a zero count closes every frame
   assign target = 13'(presampMul(presample_multiplier)) * 13'(accumulation_cycle_count);
   // equation 0 runs one program variant, 1 and 2 the other
   assign programVariant = (meter_equation_select != EQ_TAMPER);

   // element mapping per meter equation; unknown codes map like 0
   always_comb begin
      p0 = 32'(va) * 32'(iaG);
      p1 = 32'(va) * 32'(ibG);
      s0 = 32'(iaG);
      s1 = 32'(ibG);
      case (meter_equation_select)
         EQ_THREEWIRE: begin
            p0 = (32'(va) * 32'(iDiff)) >>> 1;
            p1 = (32'(va) * 32'(ibG)) >>> 1;
            s0 = 32'(iDiff);
         end
         EQ_TWOELEM: begin
            p1 = 32'(vb) * 32'(ibG);
         end
         default: begin
            p1 = 32'(va) * 32'(ibG);
         end
      endcase
   end

   // divider rounds down, so ticks run slightly fast; frame and interval counts stay exact
   assign tick = (q.tickCnt == `TICK_W'(`TICK_DIV - 1));
   assign frameEnd = tick && (q.frameCyc == `FRAME_LAST);

   // next state: frame timing, accumulation, host access
   always_comb begin
      d = q;
      d.sampleStrobe = 1'b0;
      d.accumDone = 1'b0;
      // time-base divider and thirteen-tick frame
      if (!engineEnable) begin
         d.tickCnt = '0;
         d.frameCyc = `SETTLE_CYC;
         d.frameCnt = '0;
         d.sampCnt = '0;
         d.sum0 = `WORD_RESET;
         d.sum1 = `WORD_RESET;
         d.sq0 = `WORD_RESET;
         d.sq1 = `WORD_RESET;
         d.altFrame = 1'b0;
      end else if (tick) begin
         d.tickCnt = '0;
         d.frameCyc = frameEnd ? `SETTLE_CYC : q.frameCyc + 4'h1;
      end else begin
         d.tickCnt = q.tickCnt + 11'h001;
      end
      // one sample per frame; sums wrap as two's complement
      if (engineEnable && frameEnd) begin
         d.sampleStrobe = 1'b1;
         d.frameCnt = q.frameCnt + 4'h1;
         // chopping and periodic alternate sequence only for code 00
         d.altFrame = (chop_control == 2'b00) && (q.frameCnt == `ALT_EVERY);
         d.chopPol = (chop_control == 2'b00) ? !q.chopPol : 1'b0;
         // sag threshold compares in the sag LSB scale of the samples
         d.sagA = mag(va) < sag_threshold;
         d.sagB = mag(vb) < sag_threshold;
         d.sum0 = q.sum0 + 32'(p0);
         d.sum1 = q.sum1 + 32'(p1);
         d.sq0 = q.sq0 + 32'(s0 * s0);
         d.sq1 = q.sq1 + 32'(s1 * s1);
         d.sampCnt = q.sampCnt + 13'h0001;
         if (q.sampCnt + 13'h0001 >= target) begin
            // interval closes: publish sums and restart
            d.mem[`WORD_SUM0] = d.sum0;
            d.mem[`WORD_SUM1] = d.sum1;
            d.mem[`WORD_SQ0] = d.sq0;
            d.mem[`WORD_SQ1] = d.sq1;
            d.mem[`WORD_STAT] = q.mem[`WORD_STAT] + 32'h0000_0001;
            d.sum0 = `WORD_RESET;
            d.sum1 = `WORD_RESET;
            d.sq0 = `WORD_RESET;
            d.sq1 = `WORD_RESET;
            d.sampCnt = '0;
            d.accumDone = 1'b1;
         end
      end
      // host byte port, big-endian lanes inside each word
      // a read and a write of one byte in one cycle return the old byte
      if (hostRd) begin
         d.rdData = q.mem[hostAddr[4:2]][laneBase(hostAddr[1:0]) +: 8];
      end
      // result and status words are read-only to the host
      if (hostWr && (hostAddr[4:2] >= `WORD_HOST0)) begin
         d.mem[hostAddr[4:2]][laneBase(hostAddr[1:0]) +: 8] = hostWrData;
      end
   end

   // single state register
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign hostRdData = q.rdData;
   assign sampleStrobe = q.sampleStrobe;
   assign accumDone = q.accumDone;
   assign altFrame = q.altFrame;
   assign chopPolarity = q.chopPol;
   assign sagA = q.sagA;
   assign sagB = q.sagB;

   // checks on the design's own behaviour
   frame_cap_a: assert property (
      @(posedge ref_clk) disable iff (rst) q.frameCyc <= `FRAME_LAST)
      else $error("frame cycle beyond thirteen ticks");

   frame_len_a: assert property (
      @(posedge ref_clk) disable iff (rst)
      sampleStrobe |-> $past(q.frameCyc) == `FRAME_LAST && $past(engineEnable))
      else $error("sample strobe not at frame end");

   strobe_gap_a: assert property (
      @(posedge ref_clk) disable iff (rst)
      sampleStrobe |=> !sampleStrobe [*8])
      else $error("sample strobes too close");

   byte_order_a: assert property (
      @(posedge ref_clk) disable iff (rst)
      hostRd && hostAddr[1:0] == 2'b00 && !hostWr && !frameEnd
      |=> hostRdData == q.mem[$past(hostAddr[4:2])][31:24])
      else $error("lane zero is not the top byte");

   low_byte_a: assert property (
      @(posedge ref_clk) disable iff (rst)
      hostRd && hostAddr[1:0] == 2'b11 && !hostWr && !frameEnd
      |=> hostRdData == q.mem[$past(hostAddr[4:2])][7:0])
      else $error("lane three is not the low byte");

   accum_len_a: assert property (
      @(posedge ref_clk) disable iff (rst)
      accumDone |-> $past(q.sampCnt) + 13'h0001 >= $past(target) && q.sampCnt == 13'h0000)
      else $error("interval closed early");

   variant_sel_a: assert property (
      @(posedge ref_clk) disable iff (rst)
      programVariant == (meter_equation_select == EQ_THREEWIRE
         || meter_equation_select == EQ_TWOELEM || meter_equation_select > EQ_TWOELEM))
      else $error("program variant does not follow equation");

   shunt_gain_a: assert property (
      @(posedge ref_clk) disable iff (rst)
      iaShunt |-> iaG == 15'(ia) * 15'sh0008)
      else $error("shunt gain is not eight");

   eq_one_a: assert property (
      @(posedge ref_clk) disable iff (rst)
      meter_equation_select == EQ_THREEWIRE |-> s0 == 32'(iaG) - 32'(ibG))
      else $error("equation 1 current is not difference");

   eq_two_a: assert property (
      @(posedge ref_clk) disable iff (rst)
      meter_equation_select == EQ_TWOELEM |-> p1 == 32'(vb) * 32'(ibG))
      else $error("equation 2 element two not from VB");

   chop_off_a: assert property (
      @(posedge ref_clk) disable iff (rst)
      $past(chop_control) != 2'b00 && sampleStrobe |-> !altFrame && !chopPolarity)
      else $error("chop active with chop code not 00");

   sum_wrap_a: assert property (
      @(posedge ref_clk) disable iff (rst)
      sampleStrobe |-> (accumDone ? q.mem[`WORD_SUM0] : q.sum0) == $past(q.sum0) + $past(p0))
      else $error("sum did not add the product");

   // element mapping, chop sequence, interval pulse and sag flags, valid for any input sequence
   eq_zero_a: assert property (
      @(posedge ref_clk) disable iff (rst)
      meter_equation_select == EQ_TAMPER |-> p0 == 32'(va) * 32'(iaG) && p1 == 32'(va) * 32'(ibG))
      else $error("equation 0 elements not from VA");

   half_elem_a: assert property (
      @(posedge ref_clk) disable iff (rst)
      meter_equation_select == EQ_THREEWIRE |-> s1 == 32'(ibG) && p1 == ((32'(va) * 32'(ibG)) >>> 1))
      else $error("equation 1 element two not halved");

   chop_run_a: assert property (
      @(posedge ref_clk) disable iff (rst)
      sampleStrobe && $past(chop_control) == 2'b00 |-> chopPolarity != $past(chopPolarity))
      else $error("chop polarity did not toggle");

   alt_frame_a: assert property (
      @(posedge ref_clk) disable iff (rst)
      sampleStrobe |-> altFrame == ($past(chop_control) == 2'b00 && $past(q.frameCnt) == `ALT_EVERY))
      else $error("alternate frame out of sequence");

   alt_hold_a: assert property (
      @(posedge ref_clk) disable iff (rst)
      !sampleStrobe && $past(engineEnable) |-> $stable(altFrame))
      else $error("alternate frame changed mid frame");

   accum_pulse_a: assert property (
      @(posedge ref_clk) disable iff (rst)
      accumDone |-> sampleStrobe)
      else $error("interval closed without a sample");

   sag_cmp_a: assert property (
      @(posedge ref_clk) disable iff (rst)
      sampleStrobe |-> sagA == (mag($past(va)) < $past(sag_threshold))
         && sagB == (mag($past(vb)) < $past(sag_threshold)))
      else $error("sag flag does not follow threshold");
endmodule
`default_nettype wire

// [bench/host_model.sv]
// Purpose: host model driving engine setup and the byte port
// Assumes: drives on the falling edge of ref_clk
// Notes: idle address and data show the inverse of the last value
`timescale 1ns/1ps
`default_nettype none
module host_model #(
   parameter int SUM_COUNT = 60
) (
   input wire logic ref_clk,
   output logic engineEnable,
   output logic [2:0] meter_equation_select,
   output logic [1:0] presample_multiplier,
   output logic [5:0] accumulation_cycle_count,
   output logic [1:0] chop_control,
   output logic [4:0] hostAddr,
   output logic hostRd,
   output logic hostWr,
   output logic [7:0] hostWrData,
   input wire logic [7:0] hostRdData
);
   // filter length 2, divider 4 and slot maps sit outside this block
   // engine interrupt handlers are assumed ready before enable
   initial begin
      {engineEnable, meter_equation_select, presample_multiplier} = '0;
      {accumulation_cycle_count, chop_control, hostAddr, hostRd, hostWr, hostWrData} = '0;
   end
   // setup only with the engine stopped; count is shortened by the bench
   // a non-zero chop code is only used to exercise the chop-off path
   task automatic setup(input logic [2:0] eq, input logic [1:0] ch);
      @(negedge ref_clk);
      engineEnable = 1'b0;
      meter_equation_select = eq;
      presample_multiplier = 2'h0;
      accumulation_cycle_count = 6'(SUM_COUNT);
      chop_control = ch;
      @(negedge ref_clk);
      engineEnable = 1'b1;
   endtask
   // one byte per strobe; read byte is taken one cycle later
   task automatic access(input logic wr, input logic [4:0] a, input logic [7:0] d, output logic [7:0] q);
      @(negedge ref_clk);
      hostAddr = a;
      hostWrData = d;
      hostRd = !wr;
      hostWr = wr;
      @(negedge ref_clk);
      q = hostRdData;
      hostRd = 1'b0;
      hostWr = 1'b0;
      hostAddr = ~a;
      hostWrData = ~d;
   endtask
   // words go most significant byte first
   task automatic rdWord(input logic [2:0] w, output logic [31:0] v);
      logic [7:0] b;
      for (int i = 0; i < 4; i++) begin
         access(1'b0, {w, 2'(i)}, 8'h00, b);
         v = {v[23:0], b};
      end
   endtask
   task automatic wrWord(input logic [2:0] w, input logic [31:0] v);
      logic [7:0] b;
      for (int i = 0; i < 4; i++) access(1'b1, {w, 2'(i)}, v[31-8*i -: 8], b);
   endtask
endmodule
`default_nettype wire

// [bench/compute_engine_interface_tb.sv]
// Purpose: self-checking bench for the engine interface
// Assumes: count 0 so every frame closes an interval
// Notes: four frames of about 20k clocks each
`timescale 1ns/1ps
`default_nettype none
module compute_engine_interface_tb;
   import cei_pkg::*;
   logic ref_clk = 1'b0;
   logic rst = 1'b1;
   logic engineEnable, iaShunt, ibShunt, hostRd, hostWr, programVariant, sampleStrobe;
   logic accumDone, altFrame, chopPolarity, sagA, sagB;
   logic [2:0] meter_equation_select;
   logic [1:0] presample_multiplier, chop_control;
   logic [5:0] accumulation_cycle_count;
   logic signed [11:0] va = 12'sd100, vb = 12'sd300, ia = -12'sd3, ib = 12'sd5;
   logic [11:0] sag_threshold = 12'h0C8;
   logic [4:0] hostAddr;
   logic [7:0] hostWrData, hostRdData, b;
   logic [31:0] v;
   int nFail = 0, checksDone = 0, n, e0, e1, s0;
   // 50 MHz
   always #10 ref_clk = ~ref_clk;
   compute_engine_interface i_dut (
      .ref_clk(ref_clk), .rst(rst), .engineEnable(engineEnable),
      .meter_equation_select(meter_equation_select), .presample_multiplier(presample_multiplier),
      .accumulation_cycle_count(accumulation_cycle_count), .chop_control(chop_control),
      .iaShunt(iaShunt), .ibShunt(ibShunt), .va(va), .vb(vb), .ia(ia), .ib(ib),
      .sag_threshold(sag_threshold), .hostAddr(hostAddr), .hostRd(hostRd), .hostWr(hostWr),
      .hostWrData(hostWrData), .hostRdData(hostRdData), .programVariant(programVariant),
      .sampleStrobe(sampleStrobe), .accumDone(accumDone), .altFrame(altFrame),
      .chopPolarity(chopPolarity), .sagA(sagA), .sagB(sagB));
   host_model #(.SUM_COUNT(0)) i_host (
      .ref_clk(ref_clk), .engineEnable(engineEnable), .meter_equation_select(meter_equation_select),
      .presample_multiplier(presample_multiplier), .accumulation_cycle_count(accumulation_cycle_count),
      .chop_control(chop_control), .hostAddr(hostAddr), .hostRd(hostRd), .hostWr(hostWr),
      .hostWrData(hostWrData), .hostRdData(hostRdData));
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checksDone++;
      if (seen !== exp) begin
         nFail++;
         $display("unexpected %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic testDone();
      $display("checks %0d failures %0d", checksDone, nFail);
      if (nFail == 0 && checksDone > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   initial begin
      iaShunt = 1'b0;
      ibShunt = 1'b1;
      repeat (10) @(negedge ref_clk);
      rst = 1'b0;
      // scratch words stand in for calibration copied before enable
      i_host.wrWord(3'h5, 32'h1234_5678);
      i_host.wrWord(3'h6, 32'hFFFF_FFFF);
      i_host.wrWord(3'h0, 32'hFFFF_FFFF);
      i_host.rdWord(3'h5, v);
      check("word5", v, 32'h1234_5678);
      i_host.access(1'b0, 5'h17, 8'h00, b);
      check("lsb", {24'h0, b}, 32'h0000_0078);
      i_host.rdWord(3'h6, v);
      check("minus one", v, 32'hFFFF_FFFF);
      i_host.rdWord(3'h0, v);
      check("ro word0", v, 32'h0000_0000);
      // one frame per equation, code 3 maps elements like 0 but runs the variant of 1 and 2; equation 2 runs with chop off; gains ia 1, ib 8
      for (int eq = 0; eq < 4; eq++) begin
         i_host.setup(3'(eq), (eq == 2) ? 2'h1 : 2'h0);
         check("variant", {31'h0, programVariant}, 32'(eq != 0));
         n = 0;
         while (accumDone !== 1'b1 && n < 20000) begin
            @(negedge ref_clk);
            n++;
         end
         if (n == 20000) begin
            nFail++;
            testDone();
         end
         check("frame", 32'(n > 19820 && n < 19830), 32'h0000_0001);
         check("strobe", {31'h0, sampleStrobe}, 32'h0000_0001);
         check("alt", {31'h0, altFrame}, 32'h0000_0000);
         check("chop", {31'h0, chopPolarity}, 32'(eq == 0 || eq == 3));
         if (eq == 0) begin
            check("sag", {30'h0, sagA, sagB}, 32'h0000_0002);
            i_host.rdWord(3'h4, v);
            check("count", v, 32'h0000_0001);
         end
         e0 = (eq == 1) ? (100 * -43) >>> 1 : -300;
         e1 = (eq == 1) ? 2000 : (eq == 2) ? 12000 : 4000;
         s0 = (eq == 1) ? 1849 : 9;
         i_host.rdWord(3'h0, v);
         check("sum0", v, 32'(e0));
         i_host.rdWord(3'h1, v);
         check("sum1", v, 32'(e1));
         i_host.rdWord(3'h2, v);
         check("sq0", v, 32'(s0));
         i_host.rdWord(3'h3, v);
         check("sq1", v, 32'h0000_0640);
      end
      testDone();
   end
endmodule
`default_nettype wire
